/* core/spm_power.sv */
`timescale 1ns/1ps
`default_nettype none
module spm_power #(
  parameter int NPORTS     = 3,
  parameter int PERIOD     = spm_pkg::PERIOD_CYC,
  parameter int SLEEP_UNIT = spm_pkg::SLEEP_UNIT_CYC,
  parameter int RECOVERY   = spm_pkg::RECOVERY_CYC
) (
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [11:0]         paddr,
  input  wire logic [31:0]         pwdata,
  output logic [31:0]              prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire logic [NPORTS-1:0]   cable_energy,
  input  wire logic [NPORTS-1:0]   phy_ctl_pd,
  output logic [NPORTS-1:0]        phy_pd,
  output logic                     pll_clk_en,
  output logic                     mac_clk_en,
  output logic                     host_if_en,
  output logic                     phy_rx_only,
  output logic                     link_pulse,
  output logic                     soft_reset,
  input  wire logic [NPORTS-1:0]   lpi_req,
  input  wire logic [NPORTS-1:0]   eee_ok,
  input  wire logic [4*NPORTS-1:0] mac_txd,
  input  wire logic [NPORTS-1:0]   mac_txen,
  output logic [4*NPORTS-1:0]      mii_txd,
  output logic [NPORTS-1:0]        mii_txen,
  output logic [NPORTS-1:0]        mii_txer,
  output logic [NPORTS-1:0]        mac_crs_hold,
  input  wire logic [4*NPORTS-1:0] mii_rxd,
  input  wire logic [NPORTS-1:0]   mii_rxdv,
  input  wire logic [NPORTS-1:0]   mii_rxer,
  output logic [4*NPORTS-1:0]      mac_rxd,
  output logic [NPORTS-1:0]        mac_rxdv,
  output logic [NPORTS-1:0]        mac_rxer,
  output logic [NPORTS-1:0]        partner_low_power_indication,
  output logic [NPORTS-1:0]        port_clk_en
);
  // status fields sit at bits 8 and 16, so at most eight ports fit
  if (NPORTS < 1 || NPORTS > 8) begin : g_bad_ports
    $error("port count out of range");
  end
  if (PERIOD <= spm_pkg::PULSE_CYC || SLEEP_UNIT < 1) begin : g_bad_timing
    $error("bad timing parameter");
  end

  logic [1:0]        mode_q;
  logic [7:0]        sleep_q;
  logic [NPORTS-1:0] port_pd_q;
  logic [NPORTS-1:0] lpi_en_q;
  spm_pkg::spm_ed_state_t ed_q;
  logic [31:0]       idle_cnt_q;
  logic [31:0]       unit_cnt_q;
  logic [31:0]       per_cnt_q;
  logic [NPORTS-1:0] e_s1_q;
  logic [NPORTS-1:0] e_s2_q;
  logic [NPORTS-1:0] rx_lpi_q;
  logic [NPORTS-1:0] tx_lpi;
  logic              wr_en;
  logic              rd_en;
  logic              any_energy;
  logic              wake_q;

  ////////////////////////////////////////////////////////////////////////
  // apb slave: zero wait states, unmapped addresses answer with pslverr
  assign pready = 1'b1;
  assign wr_en  = psel && penable && pwrite;
  assign rd_en  = psel && penable && !pwrite;

  always_comb begin
    pslverr = 1'b0;
    if (psel && penable) begin
      if (paddr == spm_pkg::MODE_ADDR) begin
        pslverr = 1'b0;
      end else if (paddr == spm_pkg::SLEEP_ADDR) begin
        pslverr = 1'b0;
      end else if (paddr == spm_pkg::PORT_ADDR) begin
        pslverr = 1'b0;
      end else if (paddr == spm_pkg::EEE_ADDR) begin
        pslverr = 1'b0;
      end else if (paddr == spm_pkg::STAT_ADDR) begin
        pslverr = 1'b0;
      end else begin
        pslverr = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= 32'h0000_0000;
      if (paddr == spm_pkg::MODE_ADDR) begin
        prdata[spm_pkg::MODE_MSB:spm_pkg::MODE_LSB] <= mode_q;
      end else if (paddr == spm_pkg::SLEEP_ADDR) begin
        prdata[7:0] <= sleep_q;
      end else if (paddr == spm_pkg::PORT_ADDR) begin
        prdata[NPORTS-1:0] <= port_pd_q;
      end else if (paddr == spm_pkg::EEE_ADDR) begin
        prdata[NPORTS-1:0] <= lpi_en_q;
      end else if (paddr == spm_pkg::STAT_ADDR) begin
        prdata[0]            <= ed_q == spm_pkg::SPM_ED_SLEEP;
        prdata[8+NPORTS-1:8] <= rx_lpi_q;
        prdata[16+NPORTS-1:16] <= tx_lpi;
      end
    end
  end
  // read data is latched in the setup cycle so it is stable in the access phase

  ////////////////////////////////////////////////////////////////////////
  // soft power-down wake: any access raises soft_reset one cycle later; mode, sleep, port and eee registers reset the cycle after
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_q <= 1'b0;
    end else begin
      wake_q <= (mode_q == spm_pkg::MODE_SOFTPD) && psel && penable;
    end
  end
  assign soft_reset = wake_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= spm_pkg::MODE_NORMAL;
    end else if (wake_q) begin
      mode_q <= spm_pkg::MODE_NORMAL;
    end else if (wr_en && paddr == spm_pkg::MODE_ADDR && mode_q == spm_pkg::MODE_NORMAL &&
                 pwdata[spm_pkg::MODE_MSB:spm_pkg::MODE_LSB] != spm_pkg::MODE_RSVD) begin
      mode_q <= pwdata[spm_pkg::MODE_MSB:spm_pkg::MODE_LSB];
    end else if (wr_en && paddr == spm_pkg::MODE_ADDR && mode_q == spm_pkg::MODE_EDETECT &&
                 pwdata[spm_pkg::MODE_MSB:spm_pkg::MODE_LSB] == spm_pkg::MODE_NORMAL) begin
      mode_q <= spm_pkg::MODE_NORMAL;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sleep_q   <= spm_pkg::SLEEP_RESET;
      port_pd_q <= '0;
      lpi_en_q  <= '0;
    end else if (wake_q) begin
      sleep_q   <= spm_pkg::SLEEP_RESET;
      port_pd_q <= '0;
      lpi_en_q  <= '0;
    end else if (wr_en && paddr == spm_pkg::SLEEP_ADDR) begin
      sleep_q <= pwdata[7:0];
    end else if (wr_en && paddr == spm_pkg::PORT_ADDR) begin
      port_pd_q <= pwdata[NPORTS-1:0];
    end else if (wr_en && paddr == spm_pkg::EEE_ADDR) begin
      lpi_en_q <= pwdata[NPORTS-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // energy inputs come from analog detectors, so they are synchronised
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      e_s1_q <= '0;
      e_s2_q <= '0;
    end else begin
      e_s1_q <= cable_energy;
      e_s2_q <= e_s1_q;
    end
  end
  assign any_energy = |(e_s2_q & ~port_pd_q);

  // go-sleep timer counts whole units of silence
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      unit_cnt_q <= 32'h0000_0000;
      idle_cnt_q <= 32'h0000_0000;
    end else if (mode_q != spm_pkg::MODE_EDETECT || any_energy || ed_q == spm_pkg::SPM_ED_SLEEP) begin
      unit_cnt_q <= 32'h0000_0000;
      idle_cnt_q <= 32'h0000_0000;
    end else if (unit_cnt_q == 32'(SLEEP_UNIT - 1)) begin
      unit_cnt_q <= 32'h0000_0000;
      idle_cnt_q <= idle_cnt_q + 32'h0000_0001;
    end else begin
      unit_cnt_q <= unit_cnt_q + 32'h0000_0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ed_q <= spm_pkg::SPM_ED_AWAKE;
    end else begin
      case (ed_q)
        spm_pkg::SPM_ED_AWAKE: begin
          if (mode_q == spm_pkg::MODE_EDETECT && !any_energy && idle_cnt_q > {24'h000000, sleep_q}) begin
            ed_q <= spm_pkg::SPM_ED_SLEEP;
          end
        end
        spm_pkg::SPM_ED_SLEEP: begin
          if (any_energy || mode_q != spm_pkg::MODE_EDETECT) begin
            ed_q <= spm_pkg::SPM_ED_AWAKE;
          end
        end
        default: ed_q <= spm_pkg::SPM_ED_AWAKE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // link pulse: 120 ns once a second while energy detect sees no cable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      per_cnt_q  <= 32'h0000_0000;
      link_pulse <= 1'b0;
    end else if (mode_q != spm_pkg::MODE_EDETECT || any_energy) begin
      per_cnt_q  <= 32'h0000_0000;
      link_pulse <= 1'b0;
    end else begin
      per_cnt_q  <= (per_cnt_q == 32'(PERIOD - 1)) ? 32'h0000_0000 : per_cnt_q + 32'h0000_0001;
      link_pulse <= per_cnt_q < 32'(spm_pkg::PULSE_CYC);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // global gating outputs
  always_comb begin
    pll_clk_en  = 1'b1;
    mac_clk_en  = 1'b1;
    host_if_en  = 1'b1;
    phy_rx_only = 1'b0;
    if (mode_q == spm_pkg::MODE_SOFTPD) begin
      pll_clk_en = 1'b0;
      mac_clk_en = 1'b0;
      host_if_en = 1'b0;
    end else if (ed_q == spm_pkg::SPM_ED_SLEEP) begin
      pll_clk_en  = 1'b0;
      mac_clk_en  = 1'b0;
      host_if_en  = 1'b0;
      phy_rx_only = 1'b1;
    end
  end
  // host_if_en low only tells the pads; the apb slave stays alive to catch the wake access

  always_comb begin
    phy_pd = port_pd_q | phy_ctl_pd;
    if (mode_q == spm_pkg::MODE_SOFTPD) begin
      phy_pd = '1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // per-port lpi: each direction runs on its own, one instance per port
  for (genvar p = 0; p < NPORTS; p++) begin : g_port
    spm_lpi_tx #(
      .RECOVERY (RECOVERY)
    ) u_tx (
      .pclk      (pclk),
      .presetn   (presetn),
      .lpi_req   (lpi_req[p]),
      .eee_ok    (eee_ok[p] && lpi_en_q[p]),
      .mac_txd   (mac_txd[4*p +: 4]),
      .mac_txen  (mac_txen[p]),
      .mii_txd   (mii_txd[4*p +: 4]),
      .mii_txen  (mii_txen[p]),
      .mii_txer  (mii_txer[p]),
      .mac_hold  (mac_crs_hold[p]),
      .tx_in_lpi (tx_lpi[p])
    );

    // receive detect: assert lpi is rxdv low, rxer high, rxd code
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        rx_lpi_q[p] <= 1'b0;
      end else begin
        rx_lpi_q[p] <= !mii_rxdv[p] && mii_rxer[p] && mii_rxd[4*p +: 4] == spm_pkg::LPI_CODE;
      end
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        mac_rxd[4*p +: 4] <= 4'h0;
        mac_rxdv[p]       <= 1'b0;
        mac_rxer[p]       <= 1'b0;
      end else if (!mii_rxdv[p] && mii_rxer[p] && mii_rxd[4*p +: 4] == spm_pkg::LPI_CODE) begin
        mac_rxd[4*p +: 4] <= 4'h0;
        mac_rxdv[p]       <= 1'b0;
        mac_rxer[p]       <= 1'b0;
      end else begin
        mac_rxd[4*p +: 4] <= mii_rxd[4*p +: 4];
        mac_rxdv[p]       <= mii_rxdv[p];
        mac_rxer[p]       <= mii_rxer[p];
      end
    end

    // clocks stop when mac_clk_en is low or both directions idle, since they are independent
    assign port_clk_en[p] = mac_clk_en && !(tx_lpi[p] && rx_lpi_q[p]);
  end
  assign partner_low_power_indication = rx_lpi_q;

  ////////////////////////////////////////////////////////////////////////
  mode_reserved_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && paddr == spm_pkg::MODE_ADDR && !wake_q &&
    pwdata[spm_pkg::MODE_MSB:spm_pkg::MODE_LSB] == spm_pkg::MODE_RSVD
    |=> $stable(mode_q)) else $error("reserved mode changed state");
  softpd_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
    mode_q == spm_pkg::MODE_SOFTPD |-> !pll_clk_en && !mac_clk_en && phy_pd == '1)
    else $error("soft power-down not gating");
  wake_reset_a: assert property (@(posedge pclk) disable iff (!presetn)
    mode_q == spm_pkg::MODE_SOFTPD && psel && penable |=> ##1 mode_q == spm_pkg::MODE_NORMAL
    && sleep_q == spm_pkg::SLEEP_RESET) else $error("wake access ignored");
  port_pd_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && paddr == spm_pkg::PORT_ADDR && !wake_q
    |=> (phy_pd & ($past(pwdata[NPORTS-1:0]) | phy_ctl_pd)) == ($past(pwdata[NPORTS-1:0]) | phy_ctl_pd))
    else $error("port not powered down");
  ed_wake_a: assert property (@(posedge pclk) disable iff (!presetn)
    ed_q == spm_pkg::SPM_ED_SLEEP && any_energy |=> ed_q == spm_pkg::SPM_ED_AWAKE && pll_clk_en)
    else $error("energy did not wake");
  ed_sleep_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(ed_q == spm_pkg::SPM_ED_SLEEP) |-> $past(idle_cnt_q) > {24'h000000, $past(sleep_q)})
    else $error("slept too early");
  sleep_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
    ed_q == spm_pkg::SPM_ED_SLEEP && mode_q == spm_pkg::MODE_EDETECT |-> phy_rx_only && !host_if_en)
    else $error("low-power state not gated");
  rx_lpi_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(partner_low_power_indication[0]) |-> !mac_rxdv[0] && !mac_rxer[0])
    else $error("lpi not shown as idle");
  pulse_width_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(link_pulse) |-> link_pulse [*6] ##1 !link_pulse || $fell(mode_q == spm_pkg::MODE_EDETECT))
    else $error("link pulse width wrong");

  ed_sleep_c: cover property (@(posedge pclk) disable iff (!presetn) ed_q == spm_pkg::SPM_ED_SLEEP);
  softpd_c:   cover property (@(posedge pclk) disable iff (!presetn) wake_q);
  tx_lpi_c:   cover property (@(posedge pclk) disable iff (!presetn) $fell(tx_lpi[0]));
  rx_lpi_c:   cover property (@(posedge pclk) disable iff (!presetn) $fell(rx_lpi_q[0]));
endmodule
`default_nettype wire

/* core/spm_pkg.sv */
`default_nettype none
package spm_pkg;
  // global power mode register and field layout
  localparam logic [11:0] MODE_ADDR      = 12'h000;
  localparam logic [11:0] SLEEP_ADDR     = 12'h004;
  localparam logic [11:0] PORT_ADDR      = 12'h008;
  localparam logic [11:0] EEE_ADDR       = 12'h00C;
  localparam logic [11:0] STAT_ADDR      = 12'h010;
  localparam int          MODE_LSB       = 3;
  localparam int          MODE_MSB       = 4;
  localparam int          PORT_PD_BIT    = 3;
  localparam int          PHY_PD_BIT     = 11;
  localparam logic [1:0]  MODE_NORMAL    = 2'h0;
  localparam logic [1:0]  MODE_EDETECT   = 2'h1;
  localparam logic [1:0]  MODE_SOFTPD    = 2'h2;
  localparam logic [1:0]  MODE_RSVD      = 2'h3;
  localparam logic [7:0]  SLEEP_RESET    = 8'h50;
  // mii transmit/receive codes: assert lpi is txd=0001 with tx_er, idle otherwise
  localparam logic [3:0]  LPI_CODE       = 4'h1;
  // timing
  localparam int          CLK_MHZ        = 50;
  localparam int          PULSE_NS       = 120;
  localparam int          PULSE_CYC      = (PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int          PULSE_PERIOD_S = 1;
  localparam int          PERIOD_CYC     = PULSE_PERIOD_S * CLK_MHZ * 1000000;
  localparam int          SLEEP_UNIT_MS  = 1;
  localparam int          SLEEP_UNIT_CYC = SLEEP_UNIT_MS * CLK_MHZ * 1000;
  localparam int          RECOVERY_CYC   = 30;
  typedef enum logic [1:0] {
    SPM_ED_AWAKE = 2'b00,
    SPM_ED_SLEEP = 2'b01
  } spm_ed_state_t;
endpackage
`default_nettype wire

/* core/spm_lpi_tx.sv */
`timescale 1ns/1ps
`default_nettype none
// transmit-side lpi assert function for one port
module spm_lpi_tx #(
  parameter int RECOVERY = 30
) (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       lpi_req,
  input  wire logic       eee_ok,
  input  wire logic [3:0] mac_txd,
  input  wire logic       mac_txen,
  output logic [3:0]      mii_txd,
  output logic            mii_txen,
  output logic            mii_txer,
  output logic            mac_hold,
  output logic            tx_in_lpi
);
  // the recovery counter is only 16 bits wide
  if (RECOVERY < 1 || RECOVERY > 65535) begin : g_bad_recovery
    $error("bad recovery count");
  end

  logic        req_q;
  logic [15:0] rec_q;

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_q <= 1'b0;
    end else begin
      req_q <= lpi_req && eee_ok;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rec_q <= 16'h0000;
    end else if (req_q) begin
      rec_q <= RECOVERY[15:0];
    end else if (rec_q != 16'h0000) begin
      rec_q <= rec_q - 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mii_txd  <= 4'h0;
      mii_txen <= 1'b0;
      mii_txer <= 1'b0;
    end else if (req_q) begin
      mii_txd  <= spm_pkg::LPI_CODE;
      mii_txen <= 1'b0;
      mii_txer <= 1'b1;
    end else begin
      mii_txd  <= mac_hold ? 4'h0 : mac_txd;
      mii_txen <= mac_txen && !mac_hold;
      mii_txer <= 1'b0;
    end
  end

  assign tx_in_lpi = req_q;
  assign mac_hold  = req_q || (rec_q != 16'h0000);

  rec_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(req_q) |-> mac_hold && rec_q == RECOVERY[15:0]) else $error("mac released early");
  rec_count_a: assert property (@(posedge pclk) disable iff (!presetn)
    !req_q && rec_q != 16'h0000 |=> rec_q == $past(rec_q) - 16'h0001)
    else $error("recovery count skipped");
  txen_block_a: assert property (@(posedge pclk) disable iff (!presetn)
    $past(mac_hold) |-> !mii_txen) else $error("mac sent while held");
  lpi_code_a: assert property (@(posedge pclk) disable iff (!presetn)
    req_q |=> mii_txer && mii_txd == spm_pkg::LPI_CODE) else $error("no lpi code");
  eee_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
    !$past(eee_ok) |-> !req_q) else $error("lpi without eee");
endmodule
`default_nettype wire

/* bench/spm_phy_model.sv */
`timescale 1ns/1ps
`default_nettype none
// phy receive side per port: rx_mode 0 idle, 1 assert lpi, 2 data
module spm_phy_model #(
  parameter int NPORTS = 3
) (
  input  wire logic [2*NPORTS-1:0] rx_mode,
  input  wire logic                pclk,
  input  wire logic                presetn,
  output logic [4*NPORTS-1:0]      mii_rxd,
  output logic [NPORTS-1:0]        mii_rxdv,
  output logic [NPORTS-1:0]        mii_rxer
);
  logic [3:0] cnt_q;
  ////////////////////////////////////////////////////////////////
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q    <= 4'h0;
      mii_rxd  <= '0;
      mii_rxdv <= '0;
      mii_rxer <= '0;
    end else begin
      cnt_q <= cnt_q + 4'h1;
      for (int p = 0; p < NPORTS; p++) begin
        case (rx_mode[2*p +: 2])
          2'h1: begin
            mii_rxdv[p]      <= 1'b0;
            mii_rxer[p]      <= 1'b1;
            mii_rxd[4*p +: 4] <= spm_pkg::LPI_CODE;
          end
          2'h2: begin
            mii_rxdv[p]      <= 1'b1;
            mii_rxer[p]      <= 1'b0;
            mii_rxd[4*p +: 4] <= cnt_q;
          end
          default: begin
            // idle data nibble is meaningless, so keep it moving
            mii_rxdv[p]      <= 1'b0;
            mii_rxer[p]      <= 1'b0;
            mii_rxd[4*p +: 4] <= ~cnt_q;
          end
        endcase
      end
    end
  end
endmodule
`default_nettype wire

/* bench/spm_power_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module spm_power_tb;
  localparam int NP = 3;
  localparam int RC = 5;
  logic            pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic            pll_clk_en, mac_clk_en, host_if_en, phy_rx_only, link_pulse, soft_reset, sr_seen;
  logic [11:0]     paddr;
  logic [31:0]     pwdata, prdata, rd;
  logic [NP-1:0]   cable_energy, phy_ctl_pd, phy_pd, lpi_req, eee_ok, mac_txen, mii_txen, mii_txer;
  logic [NP-1:0]   mac_crs_hold, mii_rxdv, mii_rxer, mac_rxdv, mac_rxer, port_clk_en;
  logic [NP-1:0]   partner_low_power_indication;
  logic [4*NP-1:0] mac_txd, mii_txd, mii_rxd, mac_rxd;
  logic [2*NP-1:0] rx_mode;
  int              fail_count, n_compared, pw, np_cnt, run, n, n0;
  ////////////////////////////////////////////////////////////////
  spm_power #(.NPORTS(NP), .PERIOD(100), .SLEEP_UNIT(4), .RECOVERY(RC)) uut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .cable_energy, .phy_ctl_pd, .phy_pd, .pll_clk_en, .mac_clk_en, .host_if_en, .phy_rx_only,
    .link_pulse, .soft_reset, .lpi_req, .eee_ok, .mac_txd, .mac_txen, .mii_txd, .mii_txen,
    .mii_txer, .mac_crs_hold, .mii_rxd, .mii_rxdv, .mii_rxer, .mac_rxd, .mac_rxdv, .mac_rxer,
    .partner_low_power_indication, .port_clk_en);
  spm_phy_model #(.NPORTS(NP)) phy (.rx_mode, .pclk, .presetn, .mii_rxd, .mii_rxdv, .mii_rxer);
  ////////////////////////////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  // sticky wake-reset flag and link pulse width recorder
  always @(posedge pclk) begin
    if (soft_reset === 1'b1) sr_seen <= 1'b1;
    if (link_pulse === 1'b1) run <= run + 1;
    else if (run != 0) begin
      pw     <= run;
      np_cnt <= np_cnt + 1;
      run    <= 0;
    end
  end
  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    n_compared++;
    if (got !== exp) begin
      $display("ERROR %0t %s: got %h expected %h", $time, msg, got, exp);
      fail_count++;
    end
  endtask
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    chk(pready, 1'b1, "no ready");
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  function automatic logic probe(input int k);
    case (k)
      0: probe = phy_rx_only;
      1: probe = sr_seen;
      default: probe = (np_cnt >= n0 + 2);
    endcase
  endfunction
  // bounded wait; n holds the cycles spent
  task automatic wait_until(input int k, input logic v, input int lim);
    n = 0;
    while (probe(k) !== v && n < lim) begin
      @(posedge pclk);
      #1;
      n++;
    end
    chk(probe(k), v, "wait expired");
  endtask
  task automatic stop_test;
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge pclk);
    fail_count++;
    stop_test;
  end
  ////////////////////////////////////////////////////////////////
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, sr_seen, lpi_req, mac_txd, mac_txen, rx_mode} = '0;
    {run, pw, np_cnt, fail_count, n_compared, n0} = '0;
    cable_energy = '1;
    phy_ctl_pd = '0;
    eee_ok = '1;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    #1;
    chk({pll_clk_en, mac_clk_en, host_if_en}, 3'h7, "enables after reset");
    xfer(1'b0, spm_pkg::MODE_ADDR, 32'h0);
    chk(rd[4:3], spm_pkg::MODE_NORMAL, "mode after reset");
    xfer(1'b1, spm_pkg::MODE_ADDR, {27'h0, spm_pkg::MODE_RSVD, 3'h0});
    xfer(1'b0, spm_pkg::MODE_ADDR, 32'h0);
    chk(rd[4:3], spm_pkg::MODE_NORMAL, "reserved mode taken");
    xfer(1'b1, 12'h0FC, 32'hFFFFFFFF);
    chk(err, 1'b1, "unmapped write not refused");
    xfer(1'b1, spm_pkg::PORT_ADDR, 32'h1);
    phy_ctl_pd <= 3'h2;
    @(posedge pclk);
    #1;
    chk(phy_pd, 3'h3, "port power-down");
    xfer(1'b1, spm_pkg::SLEEP_ADDR, 32'h2);
    xfer(1'b1, spm_pkg::MODE_ADDR, {27'h0, spm_pkg::MODE_EDETECT, 3'h0});
    xfer(1'b0, spm_pkg::MODE_ADDR, 32'h0);
    chk(rd[4:3], spm_pkg::MODE_EDETECT, "energy detect mode");
    cable_energy <= '0;
    wait_until(0, 1'b1, 300);
    chk(n > 8 && n < 60, 1'b1, "go-sleep time");
    chk({pll_clk_en, mac_clk_en, host_if_en}, 3'h0, "low-power gating");
    n0 = np_cnt;
    wait_until(2, 1'b1, 250);
    chk(pw, spm_pkg::PULSE_CYC, "link pulse width");
    cable_energy <= 3'h4;
    wait_until(0, 1'b0, 20);
    chk({pll_clk_en, mac_clk_en, host_if_en}, 3'h7, "wake on energy");
    cable_energy <= '1;
    xfer(1'b1, spm_pkg::MODE_ADDR, 32'h0);
    xfer(1'b1, spm_pkg::MODE_ADDR, {27'h0, spm_pkg::MODE_SOFTPD, 3'h0});
    #1;
    chk({pll_clk_en, mac_clk_en, phy_pd}, 5'h07, "soft power-down");
    chk(sr_seen, 1'b0, "early wake reset");
    xfer(1'b0, spm_pkg::STAT_ADDR, 32'h0);
    wait_until(1, 1'b1, 10);
    repeat (3) @(posedge pclk);
    xfer(1'b0, spm_pkg::SLEEP_ADDR, 32'h0);
    chk(rd[7:0], spm_pkg::SLEEP_RESET, "sleep after wake");
    xfer(1'b0, spm_pkg::PORT_ADDR, 32'h0);
    chk(rd[NP-1:0], 3'h0, "port reg after wake");
    chk(pll_clk_en, 1'b1, "clock after wake");
    xfer(1'b1, spm_pkg::EEE_ADDR, 32'h7);
    eee_ok   <= 3'h5;
    lpi_req  <= 3'h3;
    mac_txen <= 3'h2;
    mac_txd  <= 12'h050;
    rx_mode  <= 6'h21;
    repeat (3) @(posedge pclk);
    #1;
    chk(mii_txd[3:0], spm_pkg::LPI_CODE, "assert lpi code");
    chk(mii_txer, 3'h1, "lpi only where advertised");
    chk(mac_crs_hold, 3'h1, "carrier hold");
    chk({mii_txen[1], mii_txd[7:4]}, 5'h15, "other port transmits");
    chk(partner_low_power_indication, 3'h1, "partner indication");
    chk(mac_rxdv, 3'h4, "idle shown during lpi");
    chk(mac_rxer, 3'h0, "no error shown during lpi");
    chk(port_clk_en, 3'h6, "port clock gating");
    xfer(1'b0, spm_pkg::STAT_ADDR, 32'h0);
    chk(rd, 32'h0001_0100, "lpi status");
    rx_mode <= 6'h02;
    repeat (3) @(posedge pclk);
    #1;
    chk(partner_low_power_indication, 3'h0, "indication drop");
    chk(mac_rxdv[0], 1'b1, "decoding resumed");
    chk(port_clk_en, 3'h7, "clock back with rx awake");
    @(posedge pclk);
    lpi_req <= '0;
    n = 0;
    while (mac_crs_hold[0] === 1'b1 && n < 100) begin
      @(posedge pclk);
      #1;
      n++;
      if (n == 2) chk(mii_txer[0], 1'b0, "idle after drop");
    end
    chk(n >= RC && n <= RC + 3, 1'b1, "recovery delay");
    stop_test;
  end
endmodule
`default_nettype wire
